// [rtl/bus_seq_pkg.sv]
// constants, types and register map of the bus cycle sequencer
package bus_seq_pkg;

  // clocking: core clock is the oscillator, system clock is half of it
  localparam int unsigned CORE_CLK_HZ   = 20_000_000;
  localparam int unsigned SYS_CLK_DIV   = 2;
  localparam int unsigned SYS_CLK_HZ    = CORE_CLK_HZ / SYS_CLK_DIV;

  // reset pin must stay low this many system clocks to restart
  localparam logic [2:0]  RESET_MIN_SYS = 3'h6;
  localparam logic [19:0] RESTART_ADDR  = 20'h00000;

  // register byte offsets on the axi4-lite bus
  localparam logic [7:0]  OFS_WAIT_CTRL = 8'h00;
  localparam logic [7:0]  OFS_STATUS    = 8'h04;

  // field positions in dma_wait_control
  localparam int unsigned MEM_WAIT_LSB  = 6;
  localparam int unsigned IO_WAIT_LSB   = 4;
  localparam logic [7:0]  WAIT_CTRL_RST = 8'hf0;
  localparam logic [3:0]  WAIT_MAX      = 4'hf;

  // axi responses
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // machine states, one-hot
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_T1   = 7'h02,
    ST_T2   = 7'h04,
    ST_TS   = 7'h08,
    ST_T3   = 7'h10,
    ST_TI   = 7'h20,
    ST_TX   = 7'h40
  } state_t;

  // machine cycle kinds requested by the core
  typedef enum logic [2:0] {
    CYC_FETCH    = 3'h0,
    CYC_MEM_RD   = 3'h1,
    CYC_MEM_WR   = 3'h2,
    CYC_IO_RD    = 3'h3,
    CYC_IO_WR    = 3'h4,
    CYC_INTERNAL = 3'h5
  } cyc_kind_t;

  // one request from the core
  typedef struct packed {
    cyc_kind_t   kind;
    logic        int_io;
    logic [19:0] addr;
    logic [7:0]  wdata;
  } cmd_t;

endpackage : bus_seq_pkg

// [rtl/cpu_bus_cycle_sequencer.sv]
// bus cycle sequencer: machine cycles, wait states, reset restart and bus exchange
//
// Chosen here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none

module cpu_bus_cycle_sequencer (
  // clock and reset
  input  wire logic                 core_clk_i,
  input  wire logic                 rst_i,
  // axi4-lite slave
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output var  logic                 s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output var  logic                 s_axi_wready,
  output var  logic [1:0]           s_axi_bresp,
  output var  logic                 s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output var  logic                 s_axi_arready,
  output var  logic [31:0]          s_axi_rdata,
  output var  logic [1:0]           s_axi_rresp,
  output var  logic                 s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  // core request port
  input  wire bus_seq_pkg::cmd_t    cmd_i,
  input  wire logic                 cmd_valid_i,
  output var  logic                 cmd_ready_o,
  output var  logic                 cmd_done_o,
  output var  logic [7:0]           cmd_rdata_o,
  output var  logic                 restart_o,
  // external pins
  output var  logic                 sys_clk_o,
  output var  logic [19:0]          addr_o,
  output var  logic                 addr_oe_o,
  input  wire logic [7:0]           data_i,
  output var  logic [7:0]           data_o,
  output var  logic                 data_oe_o,
  output var  logic                 memory_request_n_o,
  output var  logic                 io_request_n_o,
  output var  logic                 read_strobe_n_o,
  output var  logic                 write_strobe_n_o,
  output var  logic                 ctl_oe_o,
  output var  logic                 opcode_fetch_strobe_n_o,
  input  wire logic                 wait_n_i,
  input  wire logic                 reset_n_i,
  input  wire logic                 bus_request_n_i,
  output var  logic                 bus_grant_n_o,
  output var  logic                 refresh_hold_o
);

  localparam int unsigned SW = 11;

  bus_seq_pkg::state_t state_r;
  bus_seq_pkg::state_t state_nxt;
  bus_seq_pkg::cmd_t   cur_r;
  bus_seq_pkg::cmd_t   cur_nxt;
  logic [SW-1:0]       sync1_r;
  logic [SW-1:0]       sync2_r;
  logic                wait_n_s;
  logic                reset_n_s;
  logic                breq_n_s;
  logic [7:0]          data_s;
  logic                ph_r;
  logic                breq_smp_r;
  logic                wsamp_r;
  logic [2:0]          wcnt_r;
  logic [2:0]          wcnt_load;
  logic [2:0]          rst_cnt_r;
  logic                rst_hit_r;
  logic                restart_pend_r;
  logic [7:0]          wait_ctrl_r;
  logic                accept;
  logic                k_fetch;
  logic                k_write;
  logic                k_io;
  logic                k_mem;
  logic                nph;
  logic                in_wait;
  logic [7:0]          aw_addr_r;
  logic                aw_got_r;
  logic [7:0]          w_data_r;
  logic                w_strb_r;
  logic                w_got_r;
  logic                wr_do;
  logic                ar_do;

  // two-flop synchronisers on every pin input
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_r <= {3'h7, 8'h00};
      sync2_r <= {3'h7, 8'h00};
    end else begin
      sync1_r <= {wait_n_i, reset_n_i, bus_request_n_i, data_i};
      sync2_r <= sync1_r;
    end
  end

  assign wait_n_s  = sync2_r[10];
  assign reset_n_s = sync2_r[9];
  assign breq_n_s  = sync2_r[8];
  assign data_s    = sync2_r[7:0];

  // half-phase of the system clock: 0 first half, 1 second half
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ph_r      <= 1'b0;
      sys_clk_o <= 1'b1;
    end else begin
      ph_r      <= ~ph_r;
      sys_clk_o <= ph_r;
    end
  end

  assign nph    = ~ph_r;
  assign accept = cmd_ready_o & cmd_valid_i;

  // reset pin qualification over whole system clocks
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rst_cnt_r      <= 3'h0;
      rst_hit_r      <= 1'b0;
      restart_pend_r <= 1'b1;
      restart_o      <= 1'b0;
    end else begin
      restart_o <= 1'b0;
      if (reset_n_s) begin
        rst_cnt_r <= 3'h0;
        rst_hit_r <= 1'b0;
      end else if (ph_r && rst_cnt_r != bus_seq_pkg::RESET_MIN_SYS) begin
        rst_cnt_r <= rst_cnt_r + 3'h1;
        rst_hit_r <= (rst_cnt_r + 3'h1) == bus_seq_pkg::RESET_MIN_SYS;
        restart_o <= (rst_cnt_r + 3'h1) == bus_seq_pkg::RESET_MIN_SYS;
      end
      if (rst_hit_r) begin
        restart_pend_r <= 1'b1;
      end else if (accept && cmd_i.kind == bus_seq_pkg::CYC_FETCH) begin
        restart_pend_r <= 1'b0;
      end
    end
  end

  // latch the request, forcing the restart address on the first fetch
  always_comb begin
    cur_nxt = cur_r;
    if (accept) begin
      cur_nxt = cmd_i;
      if (restart_pend_r && cmd_i.kind == bus_seq_pkg::CYC_FETCH) begin
        cur_nxt.addr = bus_seq_pkg::RESTART_ADDR;
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cur_r <= '{kind: bus_seq_pkg::CYC_INTERNAL, int_io: 1'b0, addr: 20'h00000, wdata: 8'h00};
    end else begin
      cur_r <= cur_nxt;
    end
  end

  assign k_fetch = cur_nxt.kind == bus_seq_pkg::CYC_FETCH;
  assign k_write = cur_nxt.kind == bus_seq_pkg::CYC_MEM_WR || cur_nxt.kind == bus_seq_pkg::CYC_IO_WR;
  assign k_io    = cur_nxt.kind == bus_seq_pkg::CYC_IO_RD || cur_nxt.kind == bus_seq_pkg::CYC_IO_WR;
  assign k_mem   = ~k_io & (cur_nxt.kind != bus_seq_pkg::CYC_INTERNAL);

  // programmed stretch count for the cycle being accepted
  always_comb begin
    if (cmd_i.kind == bus_seq_pkg::CYC_IO_RD || cmd_i.kind == bus_seq_pkg::CYC_IO_WR) begin
      if (cmd_i.int_io) begin
        wcnt_load = 3'h0;
      end else begin
        wcnt_load = {1'b0, wait_ctrl_r[bus_seq_pkg::IO_WAIT_LSB +: 2]} + 3'h1;
      end
    end else begin
      wcnt_load = {1'b0, wait_ctrl_r[bus_seq_pkg::MEM_WAIT_LSB +: 2]};
    end
  end

  // falling-edge samples: bus request always, wait in T2 and stretch
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      breq_smp_r <= 1'b0;
      wsamp_r    <= 1'b0;
      wcnt_r     <= 3'h0;
    end else if (rst_hit_r) begin
      breq_smp_r <= 1'b0;
      wsamp_r    <= 1'b0;
      wcnt_r     <= 3'h0;
    end else if (accept) begin
      wcnt_r <= wcnt_load;
    end else if (!ph_r) begin
      breq_smp_r <= ~breq_n_s;
      if (state_r == bus_seq_pkg::ST_T2 || state_r == bus_seq_pkg::ST_TS) begin
        wsamp_r <= ~wait_n_s | (wcnt_r != 3'h0);
        if (wcnt_r != 3'h0) begin
          wcnt_r <= wcnt_r - 3'h1;
        end
      end else begin
        wsamp_r <= 1'b0;
      end
    end
  end

  // machine state advances at the end of each system clock
  always_comb begin
    state_nxt = state_r;
    if (rst_hit_r) begin
      state_nxt = bus_seq_pkg::ST_IDLE;
    end else if (ph_r) begin
      case (state_r)
        bus_seq_pkg::ST_IDLE: begin
          if (breq_smp_r) begin
            state_nxt = bus_seq_pkg::ST_TX;
          end else if (accept) begin
            state_nxt = (cmd_i.kind == bus_seq_pkg::CYC_INTERNAL) ? bus_seq_pkg::ST_TI : bus_seq_pkg::ST_T1;
          end
        end
        bus_seq_pkg::ST_T1: state_nxt = bus_seq_pkg::ST_T2;
        bus_seq_pkg::ST_T2: state_nxt = wsamp_r ? bus_seq_pkg::ST_TS : bus_seq_pkg::ST_T3;
        bus_seq_pkg::ST_TS: state_nxt = wsamp_r ? bus_seq_pkg::ST_TS : bus_seq_pkg::ST_T3;
        bus_seq_pkg::ST_T3: state_nxt = breq_smp_r ? bus_seq_pkg::ST_TX : bus_seq_pkg::ST_IDLE;
        bus_seq_pkg::ST_TI: state_nxt = breq_smp_r ? bus_seq_pkg::ST_TX : bus_seq_pkg::ST_IDLE;
        bus_seq_pkg::ST_TX: state_nxt = breq_smp_r ? bus_seq_pkg::ST_TX : bus_seq_pkg::ST_IDLE;
        default:            state_nxt = bus_seq_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= bus_seq_pkg::ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // request port: ready only for the second half of an idle state
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cmd_ready_o <= 1'b0;
      cmd_done_o  <= 1'b0;
      cmd_rdata_o <= 8'h00;
    end else begin
      cmd_ready_o <= !ph_r && state_r == bus_seq_pkg::ST_IDLE && breq_n_s && !rst_hit_r && reset_n_s;
      cmd_done_o  <= ph_r && !rst_hit_r && (state_r == bus_seq_pkg::ST_T3 || state_r == bus_seq_pkg::ST_TI);
      if (ph_r && state_r != bus_seq_pkg::ST_T3 && state_nxt == bus_seq_pkg::ST_T3 && k_fetch) begin
        cmd_rdata_o <= data_s;
      end else if (!ph_r && state_r == bus_seq_pkg::ST_T3 && !k_fetch && !k_write) begin
        cmd_rdata_o <= data_s;
      end
    end
  end

  assign in_wait = state_nxt == bus_seq_pkg::ST_T2 || state_nxt == bus_seq_pkg::ST_TS;

  // pin outputs registered from the coming state and half
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      addr_o                  <= 20'h00000;
      addr_oe_o               <= 1'b1;
      data_o                  <= 8'h00;
      data_oe_o               <= 1'b0;
      memory_request_n_o      <= 1'b1;
      io_request_n_o          <= 1'b1;
      read_strobe_n_o         <= 1'b1;
      write_strobe_n_o        <= 1'b1;
      ctl_oe_o                <= 1'b1;
      opcode_fetch_strobe_n_o <= 1'b1;
      bus_grant_n_o           <= 1'b1;
      refresh_hold_o          <= 1'b0;
    end else begin
      if (state_nxt == bus_seq_pkg::ST_T1) begin
        addr_o <= k_io ? {4'h0, cur_nxt.addr[15:0]} : cur_nxt.addr;
        data_o <= cur_nxt.wdata;
      end
      addr_oe_o     <= state_nxt != bus_seq_pkg::ST_TX;
      ctl_oe_o      <= state_nxt != bus_seq_pkg::ST_TX;
      bus_grant_n_o <= state_nxt != bus_seq_pkg::ST_TX;
      data_oe_o     <= k_write && (in_wait || state_nxt == bus_seq_pkg::ST_T3);
      memory_request_n_o <= ~(k_mem && ((state_nxt == bus_seq_pkg::ST_T1 && nph) || in_wait ||
                             (state_nxt == bus_seq_pkg::ST_T3 && !(k_write && nph))));
      io_request_n_o     <= ~(k_io && (in_wait ||
                             (state_nxt == bus_seq_pkg::ST_T3 && !(k_write && nph))));
      read_strobe_n_o    <= ~(!k_write && ((k_mem && state_nxt == bus_seq_pkg::ST_T1 && nph) ||
                             ((k_mem || k_io) && (in_wait || state_nxt == bus_seq_pkg::ST_T3))));
      write_strobe_n_o   <= ~(k_write && (in_wait || (state_nxt == bus_seq_pkg::ST_T3 && !nph)));
      opcode_fetch_strobe_n_o <= ~(k_fetch && (state_nxt == bus_seq_pkg::ST_T1 || in_wait ||
                                  state_nxt == bus_seq_pkg::ST_T3));
      refresh_hold_o     <= state_nxt == bus_seq_pkg::ST_TS || state_nxt == bus_seq_pkg::ST_TX;
    end
  end

  // axi write side: address and data taken in either order
  assign wr_do = aw_got_r && w_got_r && !s_axi_bvalid;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      aw_got_r      <= 1'b0;
      aw_addr_r     <= 8'h00;
      w_got_r       <= 1'b0;
      w_data_r      <= 8'h00;
      w_strb_r      <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= bus_seq_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r      <= 1'b1;
        aw_addr_r     <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r      <= 1'b1;
        w_data_r     <= s_axi_wdata[7:0];
        w_strb_r     <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (wr_do) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_r[7:2] == bus_seq_pkg::OFS_WAIT_CTRL[7:2] ||
                         aw_addr_r[7:2] == bus_seq_pkg::OFS_STATUS[7:2]) ?
                        bus_seq_pkg::RESP_OKAY : bus_seq_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        aw_got_r      <= 1'b0;
        w_got_r       <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // wait control register; a qualified reset pin forces maximum stretch
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wait_ctrl_r <= bus_seq_pkg::WAIT_CTRL_RST;
    end else if (rst_hit_r) begin
      wait_ctrl_r[7:4] <= bus_seq_pkg::WAIT_MAX;
    end else if (wr_do && w_strb_r && aw_addr_r[7:2] == bus_seq_pkg::OFS_WAIT_CTRL[7:2]) begin
      wait_ctrl_r <= w_data_r;
    end
  end

  // axi read side: one read at a time, answer one edge after the address
  assign ar_do = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= bus_seq_pkg::RESP_OKAY;
    end else begin
      if (ar_do) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        if (s_axi_araddr[7:2] == bus_seq_pkg::OFS_WAIT_CTRL[7:2]) begin
          s_axi_rdata <= {24'h000000, wait_ctrl_r};
          s_axi_rresp <= bus_seq_pkg::RESP_OKAY;
        end else if (s_axi_araddr[7:2] == bus_seq_pkg::OFS_STATUS[7:2]) begin
          s_axi_rdata <= {20'h00000, rst_hit_r, restart_pend_r, ~bus_grant_n_o, wsamp_r, 1'b0, state_r};
          s_axi_rresp <= bus_seq_pkg::RESP_OKAY;
        end else begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= bus_seq_pkg::RESP_SLVERR;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule : cpu_bus_cycle_sequencer

`default_nettype wire

// [verif/bus_seq_asserts.sv]
// concurrent checks on the pins of the bus cycle sequencer
`timescale 1ns/1ns
`default_nettype none
module bus_seq_asserts (
  // clock and reset
  input wire logic        core_clk_i,
  input wire logic        rst_i,
  // pins watched
  input wire logic        sys_clk_o,
  input wire logic [19:0] addr_o,
  input wire logic        addr_oe_o,
  input wire logic        data_oe_o,
  input wire logic        ctl_oe_o,
  input wire logic        memory_request_n_o,
  input wire logic        io_request_n_o,
  input wire logic        read_strobe_n_o,
  input wire logic        write_strobe_n_o,
  input wire logic        opcode_fetch_strobe_n_o,
  input wire logic        bus_grant_n_o,
  input wire logic        refresh_hold_o,
  input wire logic        cmd_done_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  // system clock is the core clock halved
  sysclk_half_a: assert property ($rose(sys_clk_o) |=> $fell(sys_clk_o))
    else $error("system clock high longer than one core clock");
  // granted bus floats everything
  release_float_a: assert property (!bus_grant_n_o |-> !addr_oe_o && !data_oe_o && !ctl_oe_o)
    else $error("bus driven while granted");
  // grant only after every request strobe is back high
  grant_boundary_a: assert property ($fell(bus_grant_n_o) |-> $past(memory_request_n_o) && $past(io_request_n_o))
    else $error("grant in mid machine cycle");
  // i/o cycles keep the top address nibble low
  io_upper_a: assert property (!io_request_n_o && ctl_oe_o |-> addr_o[19:16] == 4'h0)
    else $error("upper address not low in i/o cycle");
  // memory and i/o requests never together
  req_excl_a: assert property (!memory_request_n_o |-> io_request_n_o)
    else $error("memory and i/o request both low");
  // write strobe only with data on the bus
  wr_data_a: assert property (!write_strobe_n_o |-> data_oe_o)
    else $error("write strobe without write data");
  // data released only after the strobes
  data_after_a: assert property ($fell(data_oe_o) |-> $past(write_strobe_n_o) && $past(memory_request_n_o) && $past(io_request_n_o))
    else $error("write data dropped before strobes");
  // stretch states freeze address, read and fetch strobes and memory request
  stretch_hold_a: assert property (refresh_hold_o && bus_grant_n_o && $past(bus_grant_n_o)
      && (!memory_request_n_o || !io_request_n_o) |-> $stable(addr_o) && $stable(read_strobe_n_o)
      && $stable(opcode_fetch_strobe_n_o) && $stable(memory_request_n_o))
    else $error("bus changed during stretch state");
  // a finished cycle has its strobes released
  done_idle_a: assert property (cmd_done_o |-> memory_request_n_o && io_request_n_o && read_strobe_n_o && write_strobe_n_o)
    else $error("strobe still low at cycle end");
endmodule : bus_seq_asserts

bind cpu_bus_cycle_sequencer bus_seq_asserts chk (.core_clk_i, .rst_i, .sys_clk_o, .addr_o, .addr_oe_o, .data_oe_o,
  .ctl_oe_o, .memory_request_n_o, .io_request_n_o, .read_strobe_n_o, .write_strobe_n_o, .opcode_fetch_strobe_n_o,
  .bus_grant_n_o, .refresh_hold_o, .cmd_done_o);
`default_nettype wire

// [verif/cpu_bus_cycle_sequencer_bench.sv]
// self-checking bench of the bus cycle sequencer
`timescale 1ns/1ns
`default_nettype none
module cpu_bus_cycle_sequencer_bench;
  logic core_clk_i;
  logic rst_i = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  bus_seq_pkg::cmd_t cmd_i = '0;
  logic cmd_valid_i = 1'b0, reset_n_i = 1'b1, bus_request_n_i = 1'b1;
  logic [4:0] wait_len = 5'h00;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, cmd_ready_o, cmd_done_o;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic restart_o, sys_clk_o, addr_oe_o, data_oe_o, ctl_oe_o, wait_n_i, bus_grant_n_o, refresh_hold_o;
  logic [7:0] cmd_rdata_o, data_o, data_i;
  logic [19:0] addr_o;
  logic memory_request_n_o, io_request_n_o, read_strobe_n_o, write_strobe_n_o, opcode_fetch_strobe_n_o;
  int n_mismatch = 0;
  int checked = 0;
  logic [31:0] n, d;
  logic [7:0] rd;
  logic [1:0] r;

  cpu_bus_cycle_sequencer dut (.core_clk_i, .rst_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cmd_i, .cmd_valid_i,
    .cmd_ready_o, .cmd_done_o, .cmd_rdata_o, .restart_o, .sys_clk_o, .addr_o, .addr_oe_o, .data_i, .data_o,
    .data_oe_o, .memory_request_n_o, .io_request_n_o, .read_strobe_n_o, .write_strobe_n_o, .ctl_oe_o,
    .opcode_fetch_strobe_n_o, .wait_n_i, .reset_n_i, .bus_request_n_i, .bus_grant_n_o, .refresh_hold_o);
  ext_bus_model mdl (.core_clk_i, .addr_i(addr_o), .ctl_oe_i(ctl_oe_o), .memory_request_n_i(memory_request_n_o),
    .io_request_n_i(io_request_n_o), .read_strobe_n_i(read_strobe_n_o), .write_strobe_n_i(write_strobe_n_o),
    .data_i(data_o), .data_oe_i(data_oe_o), .wait_len_i(wait_len), .rdata_o(data_i), .wait_n_o(wait_n_i));

  // 20 MHz core clock
  initial begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end

  task automatic end_sim();
    if (n_mismatch == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // register write, both channels offered together
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk_i);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  // one machine cycle: core edges from take to done, and the read data
  task automatic run_cycle(input bus_seq_pkg::cyc_kind_t kd, input logic io_int, input logic [19:0] a,
                           input logic [7:0] wd, output logic [31:0] n, output logic [7:0] rd);
    cmd_i <= '{kind: kd, int_io: io_int, addr: a, wdata: wd};
    cmd_valid_i <= 1'b1;
    do begin
      @(posedge core_clk_i);
    end while (!cmd_ready_o);
    cmd_valid_i <= 1'b0;
    n = '1; // counts up to the edge that launches done
    do begin
      @(posedge core_clk_i);
      n++;
    end while (!cmd_done_o);
    rd = cmd_rdata_o;
  endtask : run_cycle

  // reset values, read back, unmapped offset
  task automatic t_regs();
    axi_rd(bus_seq_pkg::OFS_WAIT_CTRL, d, r);
    check("wait ctrl reset", 32'(bus_seq_pkg::WAIT_CTRL_RST), d);
    axi_wr(bus_seq_pkg::OFS_WAIT_CTRL, 32'h0000_005a, r);
    axi_rd(bus_seq_pkg::OFS_WAIT_CTRL, d, r);
    check("wait ctrl readback", 32'h0000_005a, d);
    axi_wr(8'h08, 32'h0000_00ff, r);
    check("unmapped write resp", 32'(bus_seq_pkg::RESP_SLVERR), 32'(r));
    axi_rd(8'h08, d, r);
    check("unmapped read resp", 32'(bus_seq_pkg::RESP_SLVERR), 32'(r));
  endtask : t_regs

  // memory waits 0..3, external i/o waits 1..4, internal i/o none
  task automatic t_waits();
    for (int i = 0; i < 4; i++) begin
      axi_wr(bus_seq_pkg::OFS_WAIT_CTRL, (32'(i) << bus_seq_pkg::MEM_WAIT_LSB) | (32'(i) << bus_seq_pkg::IO_WAIT_LSB), r);
      run_cycle(bus_seq_pkg::CYC_FETCH, 1'b0, 20'(i), 8'h00, n, rd);
      check("fetch length", 32'(6 + 2 * i), n);
      check("fetch data", 32'(8'(i) ^ 8'h5a), 32'(rd));
      run_cycle(bus_seq_pkg::CYC_MEM_RD, 1'b0, 20'h00020 + 20'(i), 8'h00, n, rd);
      check("read length", 32'(6 + 2 * i), n);
      check("read data", 32'(8'(8'h20 + i) ^ 8'h5a), 32'(rd));
      run_cycle(bus_seq_pkg::CYC_IO_RD, 1'b0, 20'h00140 + 20'(i), 8'h00, n, rd);
      check("io read length", 32'(8 + 2 * i), n);
      check("io read data", 32'(8'(8'h40 + i) ^ 8'h5a), 32'(rd));
    end
    run_cycle(bus_seq_pkg::CYC_IO_WR, 1'b0, 20'h00150, 8'h11, n, rd);
    check("io write length", 32'(14), n);
    run_cycle(bus_seq_pkg::CYC_IO_WR, 1'b1, 20'h00030, 8'h22, n, rd);
    check("internal io length", 32'(6), n);
  endtask : t_waits

  // write then read back, internal cycle, external wait
  task automatic t_write_wait();
    axi_wr(bus_seq_pkg::OFS_WAIT_CTRL, 32'h0, r);
    run_cycle(bus_seq_pkg::CYC_MEM_WR, 1'b0, 20'h000a7, 8'h3c, n, rd);
    check("write length", 32'(6), n);
    run_cycle(bus_seq_pkg::CYC_MEM_RD, 1'b0, 20'h000a7, 8'h00, n, rd);
    check("written data", 32'h3c, 32'(rd));
    run_cycle(bus_seq_pkg::CYC_INTERNAL, 1'b0, 20'h0, 8'h00, n, rd);
    check("internal length", 32'(2), n);
    wait_len <= 5'h10;
    run_cycle(bus_seq_pkg::CYC_FETCH, 1'b0, 20'h00011, 8'h00, n, rd);
    check("stretched by wait", 32'h1, 32'(n > 6 && n[0] == 1'b0));
    axi_wr(bus_seq_pkg::OFS_WAIT_CTRL, 32'h0000_00c0, r);
    wait_len <= 5'h04;
    run_cycle(bus_seq_pkg::CYC_FETCH, 1'b0, 20'h00012, 8'h00, n, rd);
    check("larger of both waits", 32'(12), n);
    wait_len <= 5'h00;
  endtask : t_write_wait

  // bus exchange with an alternate master
  task automatic t_grant();
    bus_request_n_i <= 1'b0;
    do begin
      @(posedge core_clk_i);
    end while (bus_grant_n_o !== 1'b0);
    check("grant low", 32'h0, 32'(bus_grant_n_o));
    repeat (20) @(posedge core_clk_i);
    check("still granted", 32'h0, 32'(bus_grant_n_o));
    check("address floated", 32'h0, 32'(addr_oe_o));
    bus_request_n_i <= 1'b1;
    repeat (20) @(posedge core_clk_i);
    check("grant back high", 32'h1, 32'(bus_grant_n_o));
  endtask : t_grant

  // reset pin: short pulse ignored, long one restarts
  task automatic t_reset_pin(input int hold, input logic [31:0] exp);
    int seen;
    seen = 0;
    axi_wr(bus_seq_pkg::OFS_WAIT_CTRL, 32'h0, r);
    reset_n_i <= 1'b0;
    repeat (hold) begin
      @(posedge core_clk_i);
      if (restart_o) seen++;
    end
    reset_n_i <= 1'b1;
    check("restart pulse", exp, 32'(seen));
    axi_rd(bus_seq_pkg::OFS_WAIT_CTRL, d, r);
    check("wait ctrl after pin", exp != 0 ? 32'hf0 : 32'h0, d);
  endtask : t_reset_pin

  initial begin
    repeat (20) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(posedge core_clk_i);
    t_regs();
    t_waits();
    t_write_wait();
    t_grant();
    t_reset_pin(4, 32'h0);
    t_reset_pin(20, 32'h1);
    end_sim();
  end

  // cuts a hang short
  initial begin
    #2_000_000;
    n_mismatch++;
    $display("[FAIL] watchdog expected end seen hang");
    end_sim();
  end
endmodule : cpu_bus_cycle_sequencer_bench
`default_nettype wire

// [verif/ext_bus_model.sv]
// external memory and i/o device answering the sequencer's bus
`timescale 1ns/1ns
`default_nettype none
module ext_bus_model (
  // clock
  input  wire logic        core_clk_i,
  // pins from the sequencer
  input  wire logic [19:0] addr_i,
  input  wire logic        ctl_oe_i,
  input  wire logic        memory_request_n_i,
  input  wire logic        io_request_n_i,
  input  wire logic        read_strobe_n_i,
  input  wire logic        write_strobe_n_i,
  input  wire logic [7:0]  data_i,
  input  wire logic        data_oe_i,
  // slowness chosen by the bench
  input  wire logic [4:0]  wait_len_i,
  // answers
  output logic [7:0]       rdata_o,
  output logic             wait_n_o
);
  logic [7:0] mem [256];
  logic [7:0] last_r = 8'h00;
  logic [4:0] hold_r = 5'h00;
  logic       sel_r  = 1'b0;
  initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
  // drives read data while the read strobe is low, else the inverse of the last value
  assign rdata_o  = (ctl_oe_i && !read_strobe_n_i) ? mem[addr_i[7:0]] : ~last_r;
  assign wait_n_o = sel_r ? hold_r == 5'h00 : wait_len_i == 5'h00;
  // wait timer from request start, write capture
  always @(posedge core_clk_i) begin
    last_r <= rdata_o;
    sel_r  <= !memory_request_n_i || !io_request_n_i;
    if (!sel_r && (!memory_request_n_i || !io_request_n_i)) hold_r <= wait_len_i;
    else if (hold_r != 5'h00) hold_r <= hold_r - 5'h01;
    if (ctl_oe_i && data_oe_i && !write_strobe_n_i) mem[addr_i[7:0]] <= data_i;
  end
endmodule : ext_bus_model
`default_nettype wire
